// File: rtl/cssel_pkg.sv
/*
 Shared constants and types for the capacitive sense channel selector:
 register offsets, field positions, reset values, range codes and the
 channel decode function.
 Assumes a 32-bit classic Wishbone bus with byte addresses.
*/
package cssel_pkg;
   // Largest channel count the select field can address
   localparam int          CSSEL_CH_MAX    = 16;
   // Byte offsets of the two control registers
   localparam logic [3:0]  MAIN_CTRL_OFS   = 4'h0;
   localparam logic [3:0]  CHAN_CTRL_OFS   = 4'h4;
   // Field positions in the main control register
   localparam int          EN_BIT          = 7;
   localparam int          RNG_LSB         = 2;
   localparam int          DIR_BIT         = 1;
   localparam int          XSEL_BIT        = 0;
   // Field position in the channel control register
   localparam int          SEL_LSB         = 0;
   // Values after reset
   localparam logic        EN_RST          = 1'h0;
   localparam logic [1:0]  RNG_RST         = 2'h0;
   localparam logic        XSEL_RST        = 1'h0;
   localparam logic [3:0]  SEL_RST         = 4'h0;
   // Oscillator range codes
   localparam logic [1:0]  RNG_OFF         = 2'h0;
   localparam logic [1:0]  RNG_LOW         = 2'h1;
   localparam logic [1:0]  RNG_MED         = 2'h2;
   localparam logic [1:0]  RNG_HIGH        = 2'h3;

   // Current direction of the sense oscillator
   typedef enum logic {CSSEL_DIR_SINK, CSSEL_DIR_SOURCE} cssel_dir_e;

   // One-hot connection for a select code; none when off or out of range
   function automatic logic [CSSEL_CH_MAX-1:0] cssel_onehot(
      input logic       en,
      input logic [3:0] sel,
      input int         nch);
      logic [CSSEL_CH_MAX-1:0] v;
      v = '0;
      for (int i = 0; i < CSSEL_CH_MAX; i++) begin
         if (en && (i < nch) && (sel == 4'(i))) begin
            v[i] = 1'b1;
         end
      end
      return v;
   endfunction
endpackage

// File: rtl/cssel_link_if.sv
/*
 Internal link between the selector top, the channel decoder and the
 oscillator direction tracker.
 Assumes all users run on the one system clock.
*/
`timescale 1ns/10ps
interface cssel_link_if;
   import cssel_pkg::*;
   logic                    en;       // Sensing unit enabled
   logic [1:0]              range;    // Oscillator range code
   logic [3:0]              sel;      // Stored channel select code
   logic [CSSEL_CH_MAX-1:0] level;    // Synchronised pad comparator levels
   logic [CSSEL_CH_MAX-1:0] connect;  // One-hot input routed to oscillator
   logic                    hit;      // Level of the routed input
   cssel_dir_e              dir;      // Oscillator current direction

   modport dec (input en, sel, level, output connect, hit);
   modport osc (input en, range, connect, hit, output dir);
   modport ctl (output en, range, sel, level, input connect, hit, dir);
endinterface

// File: rtl/cssel_decode.sv
/*
 Channel decoder: turns the stored select code into a one-hot routing
 of one sense input to the oscillator, and reports that input's level.
 Assumes the level vector is already synchronised to the system clock.
*/
`timescale 1ns/10ps
module cssel_decode
   import cssel_pkg::*;
#(
   parameter int SENSE_CH = 16  // Implemented sense inputs, 8 or 16
) (
   cssel_link_if.dec lk         // Link to the selector top
);
   // Routing is purely combinational; the top registers the pad drive
   always_comb begin
      lk.connect = cssel_onehot(lk.en, lk.sel, SENSE_CH);
      lk.hit     = |(lk.connect & lk.level);
   end
endmodule

// File: rtl/cssel_osc.sv
/*
 Oscillator direction tracker: models the relaxation oscillator on the
 routed input, flipping between sourcing and sinking current as the
 pad comparator crosses its threshold.
 Assumes a synchronous active-high reset on the system clock.
*/
`timescale 1ns/10ps
module cssel_osc
   import cssel_pkg::*;
(
   input  wire logic clk_i,  // System clock
   input  wire logic rst_i,  // Synchronous reset, active high
   cssel_link_if.osc lk      // Link to the selector top
);
   cssel_dir_e dir_r;        // Current direction
   cssel_dir_e dir_nxt;      // Next direction
   logic       run;          // Oscillator actually running

   // Runs only when enabled, range not off and an input is routed
   always_comb begin
      run     = lk.en && (lk.range != RNG_OFF) && (|lk.connect);
      dir_nxt = dir_r;
      if (!run) begin
         dir_nxt = CSSEL_DIR_SINK;          // Idle reads as sinking
      end else begin
         case (dir_r)
            CSSEL_DIR_SOURCE: begin
               if (lk.hit) begin
                  dir_nxt = CSSEL_DIR_SINK; // Upper threshold reached
               end
            end
            CSSEL_DIR_SINK: begin
               if (!lk.hit) begin
                  dir_nxt = CSSEL_DIR_SOURCE; // Lower threshold reached
               end
            end
            default: begin
               dir_nxt = CSSEL_DIR_SINK;
            end
         endcase
      end
   end

   // Direction register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dir_r <= CSSEL_DIR_SINK;
      end else begin
         dir_r <= dir_nxt;
      end
   end

   assign lk.dir = dir_r;
endmodule

// File: rtl/cssel_top.sv
/*
 Capacitive sense channel selector with a classic Wishbone slave.
 Holds the main and channel control registers, routes one sense input
 to the oscillator, reports oscillator direction and offers the
 oscillator as the 8-bit timer's external clock.
 Assumes one system clock, a synchronous active-high reset, pad levels
 and the timer pin arriving asynchronously, and the timer source bit
 coming from logic on the same clock.
 // Function
 // - Enabled: code n routes sense input n
 // - Disabled: no input routed, code ignored
 // - Select field low four bits, RW, resets zero
 // - Upper four bits ignore writes, read zero
 // - Reduced variant: inputs 8 to 15 absent
 // - Reduced variant: top select bit reads zero
 // - Enable bit runs unit, clear powers off
 // - Range code: off, low, medium, high
 // - Status bit reads oscillator current direction
 // - Source bit routes oscillator to timer clock
*/
`timescale 1ns/10ps
module cssel_top
   import cssel_pkg::*;
#(
   parameter int SENSE_CH = 16  // Implemented sense inputs, 8 or 16
) (
   input  wire logic                    clk_i,                // Clock
   input  wire logic                    rst_i,                // Reset
   input  wire logic                    wb_cyc_i,             // Cycle
   input  wire logic                    wb_stb_i,             // Strobe
   input  wire logic                    wb_we_i,              // Write
   input  wire logic [3:0]              wb_adr_i,             // Address
   input  wire logic [3:0]              wb_sel_i,             // Lanes
   input  wire logic [31:0]             wb_dat_i,             // Wr data
   output      logic [31:0]             wb_dat_o,             // Rd data
   output      logic                    wb_ack_o,             // Ack
   input  wire logic [CSSEL_CH_MAX-1:0] sense_level_i,        // Pads
   output      logic [CSSEL_CH_MAX-1:0] sense_connect_o,      // Routing
   output      logic [1:0]              osc_range_o,          // Range
   output      logic                    unit_power_o,         // Power
   output      logic                    osc_source_o,         // Sourcing
   input  wire logic                    timer8_clock_source_i, // Ext mode
   input  wire logic                    timer8_ext_pin_i,     // Ext pin
   output      logic                    timer8_ext_clk_o      // Timer clk
);
   // Reduced variants drop the top select bit
   localparam logic [3:0] SEL_MASK = (SENSE_CH == 8) ? 4'h7 : 4'hf;

   // Only the two documented variants can be served
   generate
      if (SENSE_CH != 8 && SENSE_CH != 16) begin : g_bad_ch
         $error("SENSE_CH must be 8 or 16");
      end
   endgenerate

   cssel_link_if lk ();  // Internal link

   // Register state
   logic        en_r, en_nxt;          // Unit enable
   logic [1:0]  rng_r, rng_nxt;        // Oscillator range
   logic        xsel_r, xsel_nxt;      // Timer source select
   logic [3:0]  sel_r, sel_nxt;        // Channel select
   // Bus answer state
   logic        ack_r, ack_nxt;        // Acknowledge
   logic [31:0] dat_r, dat_nxt;        // Read data
   // Output state
   logic [CSSEL_CH_MAX-1:0] conn_r, conn_nxt;   // Pad routing
   logic [1:0]  rout_r, rout_nxt;      // Range to analog
   logic        pwr_r, pwr_nxt;        // Unit power
   logic        src_r, src_nxt;        // Direction status
   logic        tclk_r, tclk_nxt;      // Timer external clock
   // Synchronisers for asynchronous pins
   logic [CSSEL_CH_MAX-1:0] lvl_s1_r, lvl_s2_r;  // Pad levels
   logic        tpin_s1_r, tpin_s2_r;  // Timer pin
   // Decode helpers
   logic        req;                   // Request present
   logic        commit;                // Write takes effect this edge
   logic        hit_main;              // Main control selected
   logic        hit_chan;              // Channel control selected
   logic [3:0]  wr_sel_val;            // Masked select write value

   // Oscillator and decoder both live on the link
   cssel_decode #(
      .SENSE_CH (SENSE_CH)
   ) u_decode (
      .lk (lk.dec)
   );

   cssel_osc u_osc (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .lk    (lk.osc)
   );

   // Feed the link from the registers and synchronised pads
   always_comb begin
      lk.en    = en_r;
      lk.range = rng_r;
      lk.sel   = sel_r;
      lk.level = lvl_s2_r;
   end

   // Two-flop synchronisers; only the second stage is read anywhere
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lvl_s1_r  <= '0;
         lvl_s2_r  <= '0;
         tpin_s1_r <= 1'b0;
         tpin_s2_r <= 1'b0;
      end else begin
         lvl_s1_r  <= sense_level_i;
         lvl_s2_r  <= lvl_s1_r;
         tpin_s1_r <= timer8_ext_pin_i;
         tpin_s2_r <= tpin_s1_r;
      end
   end

   // Address decode and write qualification
   always_comb begin
      req        = wb_cyc_i && wb_stb_i;
      hit_main   = (wb_adr_i[3:2] == MAIN_CTRL_OFS[3:2]);
      hit_chan   = (wb_adr_i[3:2] == CHAN_CTRL_OFS[3:2]);
      // Writes land on the edge where ack is seen high
      commit     = req && wb_we_i && ack_r && wb_sel_i[0];
      // Reduced variant stores a zero top bit so it reads back zero
      wr_sel_val = wb_dat_i[SEL_LSB +: 4] & SEL_MASK;
   end

   // Next register values; upper bits are simply not stored
   always_comb begin
      en_nxt   = en_r;
      rng_nxt  = rng_r;
      xsel_nxt = xsel_r;
      sel_nxt  = sel_r;
      if (commit && hit_main) begin
         en_nxt   = wb_dat_i[EN_BIT];
         rng_nxt  = wb_dat_i[RNG_LSB +: 2];
         xsel_nxt = wb_dat_i[XSEL_BIT];
      end else if (commit && hit_chan) begin
         sel_nxt  = wr_sel_val;
      end
   end

   // Control registers, cleared by reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         en_r   <= EN_RST;
         rng_r  <= RNG_RST;
         xsel_r <= XSEL_RST;
         sel_r  <= SEL_RST;
      end else begin
         en_r   <= en_nxt;
         rng_r  <= rng_nxt;
         xsel_r <= xsel_nxt;
         sel_r  <= sel_nxt;
      end
   end

   // Bus answer: one wait cycle, then ack for exactly one cycle
   always_comb begin
      ack_nxt = req && !ack_r;
      dat_nxt = 32'h0000_0000;       // Unmapped offsets read zero
      if (req && !ack_r && !wb_we_i) begin
         if (hit_main) begin
            dat_nxt[EN_BIT]        = en_r;
            dat_nxt[RNG_LSB +: 2]  = rng_r;
            dat_nxt[DIR_BIT]       = (lk.dir == CSSEL_DIR_SOURCE);
            dat_nxt[XSEL_BIT]      = xsel_r;
         end else if (hit_chan) begin
            dat_nxt[SEL_LSB +: 4]  = sel_r;      // upper stay zero
         end
      end
   end

   // Bus answer registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
         dat_r <= 32'h0000_0000;
      end else begin
         ack_r <= ack_nxt;
         dat_r <= dat_nxt;
      end
   end

   // Registered outputs toward the analog front end and the timer
   always_comb begin
      conn_nxt = lk.connect;                     // one edge after
      pwr_nxt  = en_r;
      rout_nxt = en_r ? rng_r : RNG_OFF;         // off when shut
      src_nxt  = (lk.dir == CSSEL_DIR_SOURCE);
      // Timer external clock: oscillator or pin when external mode
      tclk_nxt = 1'b0;
      if (timer8_clock_source_i) begin
         tclk_nxt = xsel_r ? src_nxt : tpin_s2_r;
      end
   end

   // Output registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         conn_r <= '0;
         pwr_r  <= 1'b0;
         rout_r <= RNG_OFF;
         src_r  <= 1'b0;
         tclk_r <= 1'b0;
      end else begin
         conn_r <= conn_nxt;
         pwr_r  <= pwr_nxt;
         rout_r <= rout_nxt;
         src_r  <= src_nxt;
         tclk_r <= tclk_nxt;
      end
   end

   assign wb_ack_o         = ack_r;
   assign wb_dat_o         = dat_r;
   assign sense_connect_o  = conn_r;
   assign unit_power_o     = pwr_r;
   assign osc_range_o      = rout_r;
   assign osc_source_o     = src_r;
   assign timer8_ext_clk_o = tclk_r;

   // Checks on the block's own behaviour
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // A completed write to the channel control register while the unit is enabled
   sequence s_sel_write;
      req && wb_we_i && ack_r && wb_sel_i[0] && hit_chan && en_r;
   endsequence

   // The register then holds the value, the pads follow one edge later
   sequence s_sel_routed;
      ##1 (sel_r == $past(wr_sel_val))
      ##1 (sense_connect_o ==
           cssel_onehot(1'b1, $past(wr_sel_val, 2), SENSE_CH));
   endsequence

   a_sel_routed_next:
   assert property (s_sel_write |-> s_sel_routed)
      else $error("routing did not follow select write");

   a_on_route_code:
   assert property (en_r && !$past(rst_i) |=> sense_connect_o ==
                    cssel_onehot(1'b1, $past(sel_r), SENSE_CH))
      else $error("enabled routing does not match select code");

   a_off_no_route:
   assert property (!en_r [*2] |=> sense_connect_o == '0)
      else $error("input routed while unit disabled");

   a_sel_after_rst:
   assert property ($fell(rst_i) |-> sel_r == SEL_RST)
      else $error("select field not cleared by reset");

   a_chan_upper_zero:
   assert property (ack_r && $past(hit_chan && !wb_we_i)
                    |-> wb_dat_o[31:4] == 28'h0000000)
      else $error("channel register upper bits not zero");

   a_reduced_pads:
   assert property (SENSE_CH == 8 |-> sense_connect_o[15:8] == 8'h00)
      else $error("absent input routed on reduced variant");

   a_reduced_topbit:
   assert property (SENSE_CH == 8 |-> !sel_r[3])
      else $error("top select bit set on reduced variant");

   a_power_follows:
   assert property ($changed(en_r) |=> unit_power_o == $past(en_r)
                    ##1 $stable(unit_power_o) || $changed(en_r))
      else $error("unit power does not follow enable");

   a_range_off_idle:
   assert property ((rng_r == RNG_OFF) [*3] |-> !osc_source_o
                    && osc_range_o == RNG_OFF)
      else $error("oscillator active with range off");

   a_dir_readback:
   assert property (ack_r && $past(hit_main && !wb_we_i)
                    |-> wb_dat_o[DIR_BIT] == osc_source_o)
      else $error("direction status does not match oscillator");

   a_timer_osc_src:
   assert property (timer8_clock_source_i && xsel_r
                    |=> timer8_ext_clk_o == osc_source_o)
      else $error("timer clock not taken from oscillator");
endmodule

// File: verif/cssel_pad_model.sv
/*
 Electrode model for the sense pads: the routed pad charges while the
 oscillator sources current and discharges while it sinks.
 Assumes one system clock and a one-hot routing vector.
*/
`timescale 1ns/10ps
module cssel_pad_model #(
   parameter int DLY = 6              // Cycles to cross the threshold
) (
   input  wire logic        clk_i,     // System clock
   input  wire logic [15:0] connect_i, // Routing from the selector
   input  wire logic        source_i,  // Oscillator sourcing current
   output      logic [15:0] level_o    // Comparator level of each pad
);
   logic [DLY-1:0] chg_r;  // Charge history of the routed pad
   logic           wig_r;  // Pattern for pads left floating

   initial begin
      chg_r = '0;
      wig_r = 1'b0;
   end

   // Charge lags the current direction, so a slow pad is modelled
   always @(posedge clk_i) begin
      chg_r <= {chg_r[DLY-2:0], source_i};
      wig_r <= ~wig_r;
   end

   // Unrouted pads wander each cycle so no stale level can be trusted
   always_comb begin
      for (int i = 0; i < 16; i++) begin
         level_o[i] = connect_i[i] ? chg_r[DLY-1] : (wig_r ^ i[0]);
      end
   end
endmodule

// File: verif/tb.sv
/*
 Self-checking bench for the sense channel selector: a full and a
 reduced variant share one Wishbone master and one pad model.
 Assumes both variants answer each request at the same edge.
*/
`timescale 1ns/10ps
module tb
   import cssel_pkg::*;
;
   typedef struct {
      logic [3:0] adr;   // Register address
      logic [3:0] sel;   // Byte lanes of the write
      logic [7:0] wd;    // Write data
      logic [7:0] mask;  // Bits compared on read back
      logic [7:0] exp;   // Expected read, full variant
      logic [7:0] exp8;  // Expected read, reduced variant
   } cssel_row_s;

   logic        clk_i = 1'b0;  // System clock
   logic        rst_i = 1'b1;  // Synchronous reset
   logic        cyc   = 1'b0;  // Bus cycle
   logic        stb   = 1'b0;  // Bus strobe
   logic        we    = 1'b0;  // Bus write
   logic [3:0]  adr   = 4'h0;  // Bus address
   logic [3:0]  sel   = 4'h0;  // Bus lanes
   logic [31:0] wdat  = '0;    // Bus write data
   logic        tsrc  = 1'b0;  // Timer external mode
   logic        tpin  = 1'b0;  // Timer pin
   logic [31:0] dat, dat8;     // Read data of both variants
   logic        ack, ack8;     // Acknowledge of both variants
   logic [15:0] lvl, con, con8;
   logic [1:0]  rng, rng8;
   logic        pwr, pwr8, src, src8, tclk, tclk8;
   int          bad_count   = 0;
   int          comparisons = 0;
   cssel_row_s  rows [7] = '{
      '{4'h4, 4'hf, 8'hff, 8'hff, 8'h0f, 8'h07},
      '{4'h4, 4'hf, 8'h5a, 8'hff, 8'h0a, 8'h02},
      '{4'h4, 4'h0, 8'h03, 8'hff, 8'h0a, 8'h02},
      '{4'h0, 4'hf, 8'hff, 8'hfd, 8'h8d, 8'h8d},
      '{4'h0, 4'hf, 8'h00, 8'hff, 8'h00, 8'h00},
      '{4'h8, 4'hf, 8'hff, 8'hff, 8'h00, 8'h00},
      '{4'hc, 4'hf, 8'hff, 8'hff, 8'h00, 8'h00}};

   // Free-running clock, 8 ns period
   always #4 clk_i = ~clk_i;

   cssel_top #(.SENSE_CH(16)) dut (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat), .wb_ack_o(ack),
      .sense_level_i(lvl), .sense_connect_o(con), .osc_range_o(rng),
      .unit_power_o(pwr), .osc_source_o(src),
      .timer8_clock_source_i(tsrc), .timer8_ext_pin_i(tpin),
      .timer8_ext_clk_o(tclk));
   // Reduced variant listens on the same bus; its routing is not fed back
   cssel_top #(.SENSE_CH(8)) dut8 (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat8), .wb_ack_o(ack8),
      .sense_level_i(lvl), .sense_connect_o(con8), .osc_range_o(rng8),
      .unit_power_o(pwr8), .osc_source_o(src8),
      .timer8_clock_source_i(tsrc), .timer8_ext_pin_i(tpin),
      .timer8_ext_clk_o(tclk8));
   cssel_pad_model #(.DLY(6)) pads (.clk_i(clk_i), .connect_i(con),
      .source_i(src), .level_o(lvl));

   // Compare and count; never stops the run
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic stop_test;
      $display("comparisons %0d bad_count %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // One classic cycle; returns at the edge that saw ack
   task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s,
                     input logic [7:0] d, output logic [31:0] r,
                     output logic [31:0] r8);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      sel  <= s;
      wdat <= {24'hffffff, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      r  = dat;
      r8 = dat8;
      check(ack, 1'b1);
      check(ack8, 1'b1);
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
   endtask

   // Write, then look one edge after the register took the value
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      logic [31:0] r, r8;
      wb(1'b1, a, 4'hf, d, r, r8);
      @(posedge clk_i);
      #1;
   endtask

   // Count changes of a design output over a span of cycles
   task automatic toggles(input int which, output int t);
      logic p;
      t = 0;
      p = which ? tclk : src;
      repeat (200) begin
         @(posedge clk_i);
         #1;
         if ((which ? tclk : src) !== p) t++;
         p = which ? tclk : src;
      end
   endtask

   // Watchdog: the whole sequence needs far fewer cycles than this
   initial begin
      #160000;
      bad_count++;
      stop_test();
   end

   initial begin
      logic [31:0] r, r8;
      int          t;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      #1;
      check({con, rng, pwr, src, tclk}, 0);
      wb(1'b0, CHAN_CTRL_OFS, 4'hf, 8'h00, r, r8);
      check(r, 0);
      // Table of write and read-back cases
      foreach (rows[i]) begin
         wb(1'b1, rows[i].adr, rows[i].sel, rows[i].wd, r, r8);
         wb(1'b0, rows[i].adr, 4'hf, 8'h00, r, r8);
         check(r & 32'(rows[i].mask), 32'(rows[i].exp));
         check(r8 & 32'(rows[i].mask), 32'(rows[i].exp8));
      end
      // Every channel code, both variants
      wr(MAIN_CTRL_OFS, 8'h84);
      check({pwr, rng}, {1'b1, RNG_LOW});
      for (int n = 0; n < 16; n++) begin
         wr(CHAN_CTRL_OFS, 8'(n));
         check(con, 32'(1) << n);
         check(con8, 32'(1) << (n % 8));
      end
      // Every range code
      for (int k = 0; k < 4; k++) begin
         wr(MAIN_CTRL_OFS, 8'h80 | 8'(k << 2));
         check(rng, k);
      end
      // Disabled unit ignores the stored code
      wr(CHAN_CTRL_OFS, 8'h05);
      wr(MAIN_CTRL_OFS, 8'h0c);
      check({con, rng, pwr}, 0);
      // Oscillator runs on channel 2 and flips direction
      wr(CHAN_CTRL_OFS, 8'h02);
      wr(MAIN_CTRL_OFS, 8'h8c);
      check(con, 32'h4);
      toggles(0, t);
      check(t >= 4, 1'b1);
      // Timer clock: off, pin, then oscillator
      tpin <= 1'b1;
      repeat (5) @(posedge clk_i);
      #1;
      check(tclk, 1'b0);
      @(posedge clk_i);
      tsrc <= 1'b1;
      repeat (5) @(posedge clk_i);
      #1;
      check(tclk, 1'b1);
      @(posedge clk_i);
      tpin <= 1'b0;
      repeat (5) @(posedge clk_i);
      #1;
      check(tclk, 1'b0);
      wr(MAIN_CTRL_OFS, 8'h8d);
      toggles(1, t);
      check(t >= 4, 1'b1);
      // Reset in mid-run clears everything again
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      #1;
      check({con, rng, pwr, tclk}, 0);
      wb(1'b0, MAIN_CTRL_OFS, 4'hf, 8'h00, r, r8);
      check(r, 0);
      wb(1'b0, CHAN_CTRL_OFS, 4'hf, 8'h00, r, r8);
      check(r, 0);
      stop_test();
   end
endmodule
